/* verilog/rstseq_cfg.svh */
// Constants for the reset state sequencer.
`ifndef RSTSEQ_CFG_SVH
`define RSTSEQ_CFG_SVH
`define RSTSEQ_NUM_SRC      8
`define RSTSEQ_SRC_POR      0
`define RSTSEQ_SRC_PIN      1
`define RSTSEQ_SRC_CMP      2
`define RSTSEQ_SRC_SW       3
`define RSTSEQ_SRC_SUPPLY   4
`define RSTSEQ_SRC_WDOG     5
`define RSTSEQ_SRC_MCLK     6
`define RSTSEQ_SRC_FLASH    7
`define RSTSEQ_PORT_WIDTH   16
`define RSTSEQ_PC_WIDTH     16
`define RSTSEQ_PC_RESET     16'h0000
`define RSTSEQ_LATCH_RESET  1'b1
`define RSTSEQ_CLKSEL_INT   2'h0
`define RSTSEQ_RELEASE_CYC  2
`endif

/* verilog/rstseq_pkg.sv */
// Types for the reset state sequencer.
package rstseq_pkg;
    typedef enum logic [1:0] {
        RSTSEQ_RUN,
        RSTSEQ_HOLD,
        RSTSEQ_RELEASE
    } rstseq_state_t;
    typedef logic [1:0] rstseq_clksel_t;
endpackage : rstseq_pkg

/* verilog/rstseq_ctl_if.sv */
// Interface carrying the request summary between the sequencer and its helpers.
`timescale 1ns/1ps
interface rstseq_ctl_if;
    logic       any_req;
    logic       por_req;
    logic       drive_pin;
    logic [7:0] cause;
    modport src  (output any_req, output por_req, output drive_pin, output cause);
    modport seq  (input  any_req, input  por_req, input  drive_pin, input  cause);
endinterface : rstseq_ctl_if

/* verilog/rstseq_collect.sv */
// Collects the eight reset requests into one summary.
`timescale 1ns/1ps
`include "rstseq_cfg.svh"
module rstseq_collect
    import rstseq_pkg::*;
(
    // Requests, active high.
    input  wire logic [`RSTSEQ_NUM_SRC-1:0] req,
    // Summary.
    rstseq_ctl_if.src                      ctl
);
    // Any single source is enough to start reset.
    always_comb begin
        ctl.any_req   = |req;
        ctl.por_req   = req[`RSTSEQ_SRC_POR];
        // Supply monitor and power-on pull the pin low themselves.
        ctl.drive_pin = req[`RSTSEQ_SRC_POR] | req[`RSTSEQ_SRC_SUPPLY];
        ctl.cause     = req;
    end
endmodule : rstseq_collect

/* verilog/rstseq_release.sv */
// Counts the synchronous release delay after requests go away.
`timescale 1ns/1ps
`include "rstseq_cfg.svh"
module rstseq_release
    import rstseq_pkg::*;
#(
    parameter int RELEASE_CYC = `RSTSEQ_RELEASE_CYC
)
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic arst_n,
    // Control.
    input  wire logic hold,
    output logic      done
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    initial begin
        if (RELEASE_CYC < 1 || RELEASE_CYC > 255) begin
            $error("RELEASE_CYC out of range");
        end
    end
    // Restart while held so every module sees one common release edge.
    always_comb begin
        if (hold) begin
            next_cnt = 8'h00;
        end else if (cnt != RELEASE_CYC[7:0]) begin
            next_cnt = cnt + 8'h01;
        end else begin
            next_cnt = cnt;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end
    assign done = (cnt == RELEASE_CYC[7:0]);
endmodule : rstseq_release

/* verilog/rstseq_top.sv */
// Reset state sequencer top level.
`timescale 1ns/1ps
`include "rstseq_cfg.svh"
module rstseq_top
    import rstseq_pkg::*;
#(
    parameter int PORT_WIDTH  = `RSTSEQ_PORT_WIDTH,
    parameter int RELEASE_CYC = `RSTSEQ_RELEASE_CYC
)
(
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           arst_n,
    // Reset requests, active high except reset_pin_n_in, which is active low.
    input  wire logic                           por_req,
    input  wire logic                           reset_pin_n_in,
    input  wire logic                           cmp_req,
    input  wire logic                           sw_req,
    input  wire logic                           supply_req,
    input  wire logic                           wdog_req,
    input  wire logic                           mclk_req,
    input  wire logic                           flash_req,
    // Reset pin drive, open drain.
    output logic                                reset_pin_n_out,
    output logic                                reset_pin_n_oe,
    // Core control.
    output logic                                core_halt,
    output logic [`RSTSEQ_PC_WIDTH-1:0]         pc_load,
    output logic                                pc_load_en,
    // Module register reset strobes.
    output logic                                reg_reset,
    output logic                                reg_por_reset,
    // Port pin control.
    output logic [PORT_WIDTH-1:0]               port_latch_force,
    output logic                                port_force,
    output logic                                port_open_drain,
    output logic                                port_weak_pullup,
    // Interrupt, timer, watchdog and clock control.
    output logic                                irq_disable,
    output logic                                timer_disable,
    output logic                                wdog_enable,
    output rstseq_clksel_t                      clk_sel,
    output logic                                clk_sel_load,
    // Status.
    output logic [`RSTSEQ_NUM_SRC-1:0]          last_cause,
    output logic                                in_reset
);
    initial begin
        if (PORT_WIDTH < 1 || PORT_WIDTH > 64) begin
            $error("PORT_WIDTH out of range");
        end
    end

    rstseq_ctl_if ctl ();
    logic [`RSTSEQ_NUM_SRC-1:0] req;
    logic                       rel_done;

    // Gather the eight sources; the pin request arrives inverted.
    // While we pull the pin low ourselves, its low level is our own echo and
    // not a request, otherwise the reset would hold itself forever.
    always_comb begin
        req                         = '0;
        req[`RSTSEQ_SRC_POR]        = por_req;
        req[`RSTSEQ_SRC_PIN]        = ~reset_pin_n_in & ~reset_pin_n_oe;
        req[`RSTSEQ_SRC_CMP]        = cmp_req;
        req[`RSTSEQ_SRC_SW]         = sw_req;
        req[`RSTSEQ_SRC_SUPPLY]     = supply_req;
        req[`RSTSEQ_SRC_WDOG]       = wdog_req;
        req[`RSTSEQ_SRC_MCLK]       = mclk_req;
        req[`RSTSEQ_SRC_FLASH]      = flash_req;
    end

    rstseq_collect u_collect (
        .req (req),
        .ctl (ctl.src)
    );

    rstseq_state_t state;
    rstseq_state_t next_state;
    logic          pin_hold;
    logic          next_pin_hold;
    logic          por_seen;
    logic          next_por_seen;
    logic [`RSTSEQ_NUM_SRC-1:0] cause;
    logic [`RSTSEQ_NUM_SRC-1:0] next_cause;

    rstseq_release #(
        .RELEASE_CYC (RELEASE_CYC)
    ) u_release (
        .clk    (clk),
        .arst_n (arst_n),
        .hold   (ctl.any_req),
        .done   (rel_done)
    );

    // Sequencer: run, held in reset, then a clocked release.
    always_comb begin
        next_state    = state;
        next_pin_hold = pin_hold;
        next_por_seen = por_seen;
        next_cause    = cause;
        case (state)
            RSTSEQ_RUN: begin
                if (ctl.any_req) begin
                    next_state    = RSTSEQ_HOLD;
                    next_cause    = ctl.cause;
                    next_pin_hold = ctl.drive_pin;
                    next_por_seen = ctl.por_req;
                end
            end
            RSTSEQ_HOLD: begin
                // Collect every cause seen while held, so none is lost.
                next_cause    = cause | ctl.cause;
                next_pin_hold = pin_hold | ctl.drive_pin;
                next_por_seen = por_seen | ctl.por_req;
                if (!ctl.any_req) begin
                    next_state = RSTSEQ_RELEASE;
                end
            end
            RSTSEQ_RELEASE: begin
                if (ctl.any_req) begin
                    next_state    = RSTSEQ_HOLD;
                    next_cause    = cause | ctl.cause;
                    next_pin_hold = pin_hold | ctl.drive_pin;
                    next_por_seen = por_seen | ctl.por_req;
                end else if (rel_done) begin
                    next_state    = RSTSEQ_RUN;
                    next_pin_hold = 1'b0;
                    next_por_seen = 1'b0;
                end
            end
            default: begin
                next_state = RSTSEQ_HOLD;
            end
        endcase
    end

    // Reset itself lands in hold with a power-on style pin drive.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= RSTSEQ_HOLD;
            pin_hold <= 1'b1;
            por_seen <= 1'b1;
            cause    <= 8'h01;
        end else begin
            state    <= next_state;
            pin_hold <= next_pin_hold;
            por_seen <= next_por_seen;
            cause    <= next_cause;
        end
    end

    // Registered outputs; they are built from next_state, so they change on the same edge as the state.
    logic                      rst_q;
    logic                      next_rst_q;
    logic                      exit_q;
    logic                      next_exit_q;
    logic                      pin_q;
    logic                      next_pin_q;
    logic                      por_q;
    logic                      next_por_q;

    always_comb begin
        next_rst_q  = (next_state != RSTSEQ_RUN);
        next_exit_q = (state == RSTSEQ_RELEASE) && (next_state == RSTSEQ_RUN);
        next_pin_q  = next_pin_hold && (next_state != RSTSEQ_RUN);
        next_por_q  = next_por_seen && (next_state != RSTSEQ_RUN);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q  <= 1'b1;
            exit_q <= 1'b0;
            pin_q  <= 1'b1;
            por_q  <= 1'b1;
        end else begin
            rst_q  <= next_rst_q;
            exit_q <= next_exit_q;
            pin_q  <= next_pin_q;
            por_q  <= next_por_q;
        end
    end

    // Core and register control follow the reset level; reg_por_reset also needs por_seen.
    assign in_reset         = rst_q;
    assign core_halt        = rst_q;
    assign reg_reset        = rst_q;
    assign reg_por_reset    = por_q;
    // Only the open-drain enable is driven; the pin is never pulled high here.
    assign reset_pin_n_out  = 1'b0;
    assign reset_pin_n_oe   = pin_q;
    // Ports: latches high in open drain, forced while held.
    assign port_force       = rst_q;
    assign port_latch_force = {PORT_WIDTH{`RSTSEQ_LATCH_RESET}};
    assign port_open_drain  = rst_q;
    // Pull-ups are enabled in every state; no input here can change it.
    assign port_weak_pullup = 1'b1;
    assign irq_disable      = rst_q;
    assign timer_disable    = rst_q;
    // Exit actions: program counter and clock default loads held through reset and one cycle past the exit.
    assign pc_load          = `RSTSEQ_PC_RESET;
    assign pc_load_en       = rst_q | exit_q;
    assign clk_sel          = `RSTSEQ_CLKSEL_INT;
    assign clk_sel_load     = rst_q | exit_q;
    assign wdog_enable      = rst_q | exit_q;
    // No RAM control exists here, so a reset leaves RAM contents alone.
    assign last_cause       = cause;
endmodule : rstseq_top

/* tb/rstseq_checker.sv */
// Port assertions for the reset sequencer.
`timescale 1ns/1ps
`include "rstseq_cfg.svh"
module rstseq_checker
    import rstseq_pkg::*;
#(
    parameter int PORT_WIDTH  = `RSTSEQ_PORT_WIDTH,
    parameter int RELEASE_CYC = `RSTSEQ_RELEASE_CYC
)
(
    // Clock, reset and requests.
    input wire logic                   clk,
    input wire logic                   arst_n,
    input wire logic                   por_req,
    input wire logic                   reset_pin_n_in,
    input wire logic                   cmp_req,
    input wire logic                   sw_req,
    input wire logic                   supply_req,
    input wire logic                   wdog_req,
    input wire logic                   mclk_req,
    input wire logic                   flash_req,
    // Reset outputs.
    input wire logic                   reset_pin_n_out,
    input wire logic                   reset_pin_n_oe,
    input wire logic                   core_halt,
    input wire logic [15:0]            pc_load,
    input wire logic                   pc_load_en,
    input wire logic                   reg_reset,
    input wire logic                   reg_por_reset,
    input wire logic [PORT_WIDTH-1:0]  port_latch_force,
    input wire logic                   port_force,
    input wire logic                   port_open_drain,
    input wire logic                   port_weak_pullup,
    input wire logic                   irq_disable,
    input wire logic                   timer_disable,
    input wire logic                   wdog_enable,
    input wire rstseq_clksel_t         clk_sel,
    input wire logic                   clk_sel_load,
    input wire logic [7:0]             last_cause,
    input wire logic                   in_reset
);
    logic [7:0] req;
    logic [3:0] quiet;
    logic [3:0] next_quiet;
    // Requests in cause bit order; a low pin is a request only when the device is not
    // pulling it low itself.
    assign req = {flash_req, mclk_req, wdog_req, supply_req, sw_req, cmp_req,
                  !reset_pin_n_in && !reset_pin_n_oe, por_req};
    // Counts reset cycles with no request left, saturating so it never wraps.
    always_comb begin
        next_quiet = (in_reset && req == 8'h00) ? quiet + 4'h1 : 4'h0;
        if (quiet == 4'hf)
            next_quiet = quiet;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            quiet <= 4'h0;
        else
            quiet <= next_quiet;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    enter_on_req_a: assert property (|req |-> ##[1:2] in_reset)
        else $error("reset not entered after a request");
    halt_tie_a: assert property (core_halt == in_reset && reg_reset == in_reset
        && irq_disable == in_reset && timer_disable == in_reset)
        else $error("halt or disables differ from reset state");
    port_state_a: assert property (in_reset |-> port_force && port_open_drain
        && &port_latch_force) else $error("ports not forced during reset");
    pullup_on_a: assert property (port_weak_pullup)
        else $error("weak pullups off");
    pin_drive_a: assert property ((por_req || supply_req) |-> ##[1:2]
        (reset_pin_n_oe && !reset_pin_n_out)) else $error("reset pin not driven low");
    pin_only_reset_a: assert property (reset_pin_n_oe |-> in_reset)
        else $error("reset pin driven outside reset");
    exit_defaults_a: assert property ($fell(in_reset) |-> pc_load_en && wdog_enable
        && clk_sel_load
        && pc_load == `RSTSEQ_PC_RESET && clk_sel == `RSTSEQ_CLKSEL_INT ##1 !pc_load_en)
        else $error("exit defaults wrong");
    cause_kept_a: assert property (|req |-> ##2 ((last_cause & $past(req, 2))
        == $past(req, 2))) else $error("cause not recorded");
    por_bits_a: assert property (por_req |-> ##[1:2] reg_por_reset)
        else $error("power-on register reset missing");
    release_hold_a: assert property ($fell(|req) |-> ##1 in_reset)
        else $error("reset released without delay");
    release_bound_a: assert property (quiet <= 4'(RELEASE_CYC + 3))
        else $error("reset held too long after requests went away");
    cover property ($fell(in_reset));
    cover property (in_reset && reset_pin_n_oe);
    cover property ($fell(|req) ##1 |req);
endmodule : rstseq_checker

/* tb/rstseq_src_model.sv */
// Far side model: reset sources and the open-drain reset pin.
`timescale 1ns/1ps
module rstseq_src_model (
    // Levels asked by the bench; bit one means the reset button is pressed.
    input  wire logic [7:0] ask,
    // Device drive of the reset pin.
    input  wire logic       pin_out,
    input  wire logic       pin_oe,
    // Levels seen by the device.
    output logic [7:0]      lvl
);
    // The pin has a pull-up, so it reads high unless some party pulls it low.
    assign lvl = {ask[7:2], !(ask[1] || (pin_oe && !pin_out)), ask[0]};
endmodule : rstseq_src_model

/* tb/test_rstseq_top.sv */
// Self-checking bench for the reset sequencer.
`timescale 1ns/1ps
`include "rstseq_cfg.svh"
module test_rstseq_top;
    import rstseq_pkg::*;
    logic           clk, arst_n, was_in, reset_pin_n_out, reset_pin_n_oe, core_halt;
    logic           pc_load_en, reg_reset, reg_por_reset, port_force, port_open_drain;
    logic           port_weak_pullup, irq_disable, timer_disable, wdog_enable;
    logic           clk_sel_load, in_reset;
    logic [15:0]    pc_load, port_latch_force;
    logic [7:0]     ask, lvl, last_cause, carry, e;
    rstseq_clksel_t clk_sel;
    logic [7:0]     exp_q[$];
    int             num_errors, num_checks, seed;
    rstseq_src_model src_u (.ask, .pin_out(reset_pin_n_out), .pin_oe(reset_pin_n_oe), .lvl);
    rstseq_top dut_u (.clk, .arst_n, .por_req(lvl[0]), .reset_pin_n_in(lvl[1]),
        .cmp_req(lvl[2]), .sw_req(lvl[3]), .supply_req(lvl[4]), .wdog_req(lvl[5]),
        .mclk_req(lvl[6]), .flash_req(lvl[7]), .reset_pin_n_out, .reset_pin_n_oe,
        .core_halt, .pc_load, .pc_load_en, .reg_reset, .reg_por_reset, .port_latch_force,
        .port_force, .port_open_drain, .port_weak_pullup, .irq_disable, .timer_disable,
        .wdog_enable, .clk_sel, .clk_sel_load, .last_cause, .in_reset);
    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // Bounded wait for the exit, then a few idle cycles before the next request.
    task automatic wait_exit;
        for (int k = 0; k < 40 && in_reset !== 1'b0; k++)
            @(negedge clk);
        repeat (3) @(negedge clk);
    endtask : wait_exit
    // Holds a request mix for n cycles, checks the reset state, notes the cause.
    task automatic hit(input logic [7:0] m, input int n);
        ask = m;
        repeat (n) @(negedge clk);
        check(in_reset, 1'b1);
        check({core_halt, irq_disable, timer_disable}, 3'h7);
        check({port_force, port_open_drain, &port_latch_force}, 3'h7);
        check(reset_pin_n_oe, |(m & 8'h11));
        check(reg_por_reset, m[0]);
        exp_q.push_back(m | carry);
        carry = 8'h00;
        ask = 8'h00;
        wait_exit();
    endtask : hit
    // Each exit from reset takes the oldest note and compares the exit state.
    always @(negedge clk) begin
        if (arst_n === 1'b1 && was_in === 1'b1 && in_reset === 1'b0) begin
            check(exp_q.size() > 0, 1'b1);
            e = exp_q.pop_front();
            check(last_cause, e);
            check(pc_load, `RSTSEQ_PC_RESET);
            check({pc_load_en, wdog_enable, clk_sel_load, clk_sel}, 5'h1c);
            check(port_weak_pullup, 1'b1);
        end
        was_in <= in_reset;
    end
    // Main sequence: power-on, every source alone, random mixes, re-request, async reset.
    initial begin
        seed = 32'h830d;
        ask = 8'h00;
        carry = 8'h00;
        arst_n = 1'b0;
        num_errors = 0;
        num_checks = 0;
        exp_q.push_back(8'h01);
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        wait_exit();
        for (int i = 0; i < 8; i++)
            hit(8'h01 << i, 3 + ($random(seed) & 3));
        repeat (6) hit(8'($random(seed)) | 8'h08, 4);
        // A request arriving during the release delay joins the same reset.
        ask = 8'h04;
        repeat (4) @(negedge clk);
        ask = 8'h00;
        @(negedge clk);
        carry = 8'h04;
        hit(8'h40, 3);
        // Asynchronous reset in the middle of a software reset.
        ask = 8'h08;
        repeat (3) @(negedge clk);
        arst_n = 1'b0;
        ask = 8'h00;
        exp_q.push_back(8'h01);
        @(negedge clk);
        check(reset_pin_n_oe, 1'b1);
        arst_n = 1'b1;
        wait_exit();
        check(exp_q.size() == 0, 1'b1);
        complete_run();
    end
    // Hang guard well beyond the few hundred cycles the sequence needs.
    initial begin
        #20us;
        num_errors++;
        complete_run();
    end
endmodule : test_rstseq_top
bind rstseq_top rstseq_checker #(.PORT_WIDTH(PORT_WIDTH), .RELEASE_CYC(RELEASE_CYC)) chk_u (
    .clk, .arst_n, .por_req, .reset_pin_n_in, .cmp_req, .sw_req, .supply_req, .wdog_req,
    .mclk_req, .flash_req, .reset_pin_n_out, .reset_pin_n_oe, .core_halt, .pc_load,
    .pc_load_en, .reg_reset, .reg_por_reset, .port_latch_force, .port_force,
    .port_open_drain, .port_weak_pullup, .irq_disable, .timer_disable, .wdog_enable,
    .clk_sel, .clk_sel_load, .last_cause, .in_reset);
